// ---- verilog/abs_track_pkg.sv ----
package abs_track_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0]  OFS_RESET_CMD  = 8'h00;
   localparam logic [7:0]  OFS_ORIGIN     = 8'h04;
   localparam logic [7:0]  OFS_ENC_TYPE   = 8'h08;
   localparam logic [7:0]  OFS_IN_TURN    = 8'h0c;
   localparam logic [7:0]  OFS_REVS       = 8'h10;
   localparam logic [7:0]  OFS_CUR_POS    = 8'h14;
   localparam logic [7:0]  OFS_STATUS     = 8'h18;

   // Encoder geometry
   localparam int          POS17_BITS     = 17;
   localparam int          POS23_BITS     = 23;
   localparam int          TURN_BITS      = 16;
   localparam int          ABS_BITS       = POS23_BITS + TURN_BITS;

   // Reset values and limits
   localparam logic [15:0] RESET_CMD_NOP  = 16'h0000;
   localparam logic [15:0] RESET_CMD_GO   = 16'h0001;
   localparam logic [31:0] ORIGIN_RST     = 32'h0000_0000;
   localparam logic [31:0] ORIGIN_MIN     = 32'h8000_0001;
   localparam logic [31:0] ORIGIN_MAX     = 32'h7fff_fffe;
   localparam logic [1:0]  ENC_TYPE_RST   = 2'h1;

   // Status bit positions
   localparam int          ST_FAULT_BIT   = 0;
   localparam int          ST_BUSY_BIT    = 1;

   // Bus codes
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic        HRESP_OKAY     = 1'b0;

   // Encoder kinds, register code is the enum order
   typedef enum logic [1:0] {
      ENC_SINGLE_MAG,
      ENC_MULTI_MAG,
      ENC_MULTI_OPT
   } enc_type_t;

   // Multi-turn reset sequencer
   typedef enum logic {
      CMD_IDLE,
      CMD_APPLY
   } cmd_state_t;

   // One position report from the encoder
   typedef struct packed {
      logic                  valid;
      logic                  fault;
      logic [TURN_BITS-1:0]  turns;
      logic [POS23_BITS-1:0] pos;
   } enc_sample_t;

endpackage : abs_track_pkg

// ---- verilog/abs_position_former.sv ----
`timescale 1ns/100ps
`default_nettype none
module abs_position_former (
   // Clock and reset
   input  wire logic                                       mclk,
   input  wire logic                                       rst_n,
   // Encoder report and selected encoder kind
   input  wire abs_track_pkg::enc_sample_t                 enc,
   input  wire logic [1:0]                                 enc_type,
   // Registered, kind-masked sample
   output logic                                            sample_q,
   output logic                                            fault_q,
   output logic [abs_track_pkg::POS23_BITS-1:0]            in_turn_q,
   output logic [abs_track_pkg::TURN_BITS-1:0]             turns_q,
   output logic [abs_track_pkg::ABS_BITS-1:0]              abs_q
);

   // Joins turn count and in-turn position as one absolute count
   function automatic logic [abs_track_pkg::ABS_BITS-1:0] join_abs(
      input logic [abs_track_pkg::TURN_BITS-1:0]  turns,
      input logic [abs_track_pkg::POS23_BITS-1:0] pos,
      input logic [1:0]                           kind);
      case (kind)
         abs_track_pkg::ENC_MULTI_OPT: join_abs = {turns, pos};
         abs_track_pkg::ENC_MULTI_MAG: join_abs = {6'h00, turns, pos[abs_track_pkg::POS17_BITS-1:0]};
         default:                      join_abs = {22'h000000, pos[abs_track_pkg::POS17_BITS-1:0]};
      endcase
   endfunction : join_abs

   logic                                 sample_d;
   logic                                 fault_d;
   logic [abs_track_pkg::POS23_BITS-1:0] in_turn_d;
   logic [abs_track_pkg::TURN_BITS-1:0]  turns_d;
   logic [abs_track_pkg::ABS_BITS-1:0]   abs_d;

   // Mask the report to the kind's width; single-turn ignores any turn data
   always_comb begin
      sample_d  = enc.valid;
      fault_d   = enc.valid & enc.fault;
      in_turn_d = in_turn_q;
      turns_d   = turns_q;
      abs_d     = abs_q;
      if (enc.valid) begin
         if (enc_type == abs_track_pkg::ENC_MULTI_OPT) begin
            in_turn_d = enc.pos;
         end else begin
            in_turn_d = {6'h00, enc.pos[abs_track_pkg::POS17_BITS-1:0]};
         end
         turns_d = (enc_type == abs_track_pkg::ENC_SINGLE_MAG) ? 16'h0000 : enc.turns;
         abs_d   = join_abs(enc.turns, enc.pos, enc_type);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sample_q  <= 1'b0;
         fault_q   <= 1'b0;
         in_turn_q <= '0;
         turns_q   <= '0;
         abs_q     <= '0;
      end else begin
         sample_q  <= sample_d;
         fault_q   <= fault_d;
         in_turn_q <= in_turn_d;
         turns_q   <= turns_d;
         abs_q     <= abs_d;
      end
   end

endmodule : abs_position_former
`default_nettype wire

// ---- verilog/absolute_position_tracker.sv ----
`timescale 1ns/100ps
`default_nettype none
module absolute_position_tracker (
   // Clock and reset
   input  wire logic                                mclk,
   input  wire logic                                rst_n,
   // AHB-Lite slave
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic                                     hreadyout,
   output logic [31:0]                              hrdata,
   output logic                                     hresp,
   // Encoder side
   input  wire abs_track_pkg::enc_sample_t          enc,
   output logic                                     enc_clear_turns,
   // Current multi-turn position for the position loop
   output logic [31:0]                              cur_position
);

   // Clamps a written origin into its signed range
   function automatic logic [31:0] clamp_origin(input logic [31:0] v);
      if ($signed(v) < $signed(abs_track_pkg::ORIGIN_MIN)) begin
         clamp_origin = abs_track_pkg::ORIGIN_MIN;
      end else if ($signed(v) > $signed(abs_track_pkg::ORIGIN_MAX)) begin
         clamp_origin = abs_track_pkg::ORIGIN_MAX;
      end else begin
         clamp_origin = v;
      end
   endfunction : clamp_origin

   // Registered sample from the former
   logic                                     smp_valid;
   logic                                     smp_fault;
   logic [abs_track_pkg::POS23_BITS-1:0]     smp_in_turn;
   logic [abs_track_pkg::TURN_BITS-1:0]      smp_turns;
   logic [abs_track_pkg::ABS_BITS-1:0]       smp_abs;

   // Bus state
   logic                                     wr_pend_q, wr_pend_d;
   logic [7:0]                               waddr_q, waddr_d;
   logic [31:0]                              hrdata_q, hrdata_d;
   logic                                     hreadyout_q;

   // Software registers
   logic [15:0]                              cmd_q, cmd_d;
   logic [31:0]                              origin_q, origin_d;
   logic [1:0]                               etype_q, etype_d;
   abs_track_pkg::cmd_state_t                state_q, state_d;

   // Tracking state
   logic [abs_track_pkg::ABS_BITS-1:0]       abs_base_q, abs_base_d;
   logic [abs_track_pkg::TURN_BITS-1:0]      turn_base_q, turn_base_d;
   logic [31:0]                              org_base_q, org_base_d;
   logic [31:0]                              cur_q, cur_d;
   logic [31:0]                              in_turn_q, in_turn_d;
   logic [31:0]                              revs_q, revs_d;
   logic                                     fault_q, fault_d;
   logic                                     clr_q, clr_d;

   logic [abs_track_pkg::ABS_BITS-1:0]       abs_delta;
   logic [abs_track_pkg::TURN_BITS-1:0]      turn_delta;
   logic                                     addr_phase;

   abs_position_former u_former (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .enc       (enc),
      .enc_type  (etype_q),
      .sample_q  (smp_valid),
      .fault_q   (smp_fault),
      .in_turn_q (smp_in_turn),
      .turns_q   (smp_turns),
      .abs_q     (smp_abs)
   );

   assign addr_phase = hsel & hready & (htrans == abs_track_pkg::HTRANS_NONSEQ);
   assign abs_delta  = smp_abs - abs_base_q;
   assign turn_delta = smp_turns - turn_base_q;

   // Bus: reads answered in the data phase, writes land when hwdata is valid
   always_comb begin
      wr_pend_d = addr_phase & hwrite;
      waddr_d   = addr_phase ? haddr[7:0] : waddr_q;
      hrdata_d  = hrdata_q;
      if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            abs_track_pkg::OFS_RESET_CMD: hrdata_d = {16'h0000, cmd_q};
            abs_track_pkg::OFS_ORIGIN:    hrdata_d = origin_q;
            abs_track_pkg::OFS_ENC_TYPE:  hrdata_d = {30'h00000000, etype_q};
            abs_track_pkg::OFS_IN_TURN:   hrdata_d = in_turn_q;
            abs_track_pkg::OFS_REVS:      hrdata_d = revs_q;
            abs_track_pkg::OFS_CUR_POS:   hrdata_d = cur_q;
            abs_track_pkg::OFS_STATUS:    hrdata_d = {30'h00000000, state_q == abs_track_pkg::CMD_APPLY, fault_q};
            default:                      hrdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend_q   <= 1'b0;
         waddr_q     <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b0;
      end else begin
         wr_pend_q   <= wr_pend_d;
         waddr_q     <= waddr_d;
         hrdata_q    <= hrdata_d;
         hreadyout_q <= 1'b1; // Zero wait states; low only during reset
      end
   end

   // Software registers and the reset-command sequencer
   always_comb begin
      cmd_d    = cmd_q;
      origin_d = origin_q;
      etype_d  = etype_q;
      state_d  = state_q;
      case (state_q)
         abs_track_pkg::CMD_IDLE: begin
            if (wr_pend_q && waddr_q == abs_track_pkg::OFS_RESET_CMD &&
                hwdata[15:0] == abs_track_pkg::RESET_CMD_GO) begin
               cmd_d   = abs_track_pkg::RESET_CMD_GO;
               state_d = abs_track_pkg::CMD_APPLY;
            end
         end
         abs_track_pkg::CMD_APPLY: begin
            cmd_d   = abs_track_pkg::RESET_CMD_NOP;
            state_d = abs_track_pkg::CMD_IDLE;
         end
         default: begin
            state_d = abs_track_pkg::CMD_IDLE;
         end
      endcase
      if (wr_pend_q && waddr_q == abs_track_pkg::OFS_ORIGIN) begin
         origin_d = clamp_origin(hwdata);
      end
      if (wr_pend_q && waddr_q == abs_track_pkg::OFS_ENC_TYPE && hwdata[1:0] != 2'h3) begin
         etype_d = hwdata[1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cmd_q    <= abs_track_pkg::RESET_CMD_NOP;
         origin_q <= abs_track_pkg::ORIGIN_RST;
         etype_q  <= abs_track_pkg::ENC_TYPE_RST;
         state_q  <= abs_track_pkg::CMD_IDLE;
      end else begin
         cmd_q    <= cmd_d;
         origin_q <= origin_d;
         etype_q  <= etype_d;
         state_q  <= state_d;
      end
   end

   // Position tracking; bases start at zero so power-up reads the encoder as is
   always_comb begin
      abs_base_d  = abs_base_q;
      turn_base_d = turn_base_q;
      org_base_d  = org_base_q;
      cur_d       = cur_q;
      in_turn_d   = in_turn_q;
      revs_d      = revs_q;
      fault_d     = fault_q;
      clr_d       = 1'b0;
      if (state_q == abs_track_pkg::CMD_APPLY) begin
         abs_base_d  = smp_abs;
         turn_base_d = smp_turns;
         org_base_d  = origin_q;
         cur_d       = origin_q;
         revs_d      = 32'h0000_0000;
         fault_d     = 1'b0;
         clr_d       = 1'b1;
      end else if (smp_valid) begin
         cur_d  = org_base_q + abs_delta[31:0];
         // Single-turn shows no turns even if a base was captured under a multi-turn kind
         revs_d = (etype_q == abs_track_pkg::ENC_SINGLE_MAG) ? 32'h0000_0000 : {16'h0000, turn_delta};
      end
      if (smp_valid) begin
         in_turn_d = {9'h000, smp_in_turn};
      end
      // A fault reported in the clearing cycle is kept
      if (smp_fault) begin
         fault_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         abs_base_q  <= '0;
         turn_base_q <= '0;
         org_base_q  <= abs_track_pkg::ORIGIN_RST;
         cur_q       <= 32'h0000_0000;
         in_turn_q   <= 32'h0000_0000;
         revs_q      <= 32'h0000_0000;
         fault_q     <= 1'b0;
         clr_q       <= 1'b0;
      end else begin
         abs_base_q  <= abs_base_d;
         turn_base_q <= turn_base_d;
         org_base_q  <= org_base_d;
         cur_q       <= cur_d;
         in_turn_q   <= in_turn_d;
         revs_q      <= revs_d;
         fault_q     <= fault_d;
         clr_q       <= clr_d;
      end
   end

   assign hreadyout       = hreadyout_q;
   assign hrdata          = hrdata_q;
   assign hresp           = abs_track_pkg::HRESP_OKAY;
   assign enc_clear_turns = clr_q;
   assign cur_position    = cur_q;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_go_write;
      wr_pend_q && waddr_q == abs_track_pkg::OFS_RESET_CMD && hwdata[15:0] == abs_track_pkg::RESET_CMD_GO
      && state_q == abs_track_pkg::CMD_IDLE;
   endsequence

   sequence s_apply_then_idle;
      state_q == abs_track_pkg::CMD_APPLY ##1 state_q == abs_track_pkg::CMD_IDLE && cmd_q == 16'h0000;
   endsequence

   property p_cmd_once;
      s_go_write |=> s_apply_then_idle;
   endproperty
   a_cmd_once: assert property (p_cmd_once) else $error("reset command did not act once");

   property p_load_origin;
      state_q == abs_track_pkg::CMD_APPLY |=> cur_q == $past(origin_q) && enc_clear_turns;
   endproperty
   a_load_origin: assert property (p_load_origin) else $error("position not loaded from origin");

   property p_clear_revs;
      state_q == abs_track_pkg::CMD_APPLY && !smp_fault |=> revs_q == 32'h0000_0000 && !fault_q;
   endproperty
   a_clear_revs: assert property (p_clear_revs) else $error("reset did not clear count or fault");

   property p_nop_write;
      wr_pend_q && waddr_q == abs_track_pkg::OFS_RESET_CMD && hwdata[15:0] == 16'h0000 && state_q == abs_track_pkg::CMD_IDLE
      |=> state_q == abs_track_pkg::CMD_IDLE;
   endproperty
   a_nop_write: assert property (p_nop_write) else $error("zero write started a reset");

   property p_origin_range;
      $signed(origin_q) >= $signed(abs_track_pkg::ORIGIN_MIN) && $signed(origin_q) <= $signed(abs_track_pkg::ORIGIN_MAX);
   endproperty
   a_origin_range: assert property (p_origin_range) else $error("origin offset out of range");

   property p_origin_now;
      wr_pend_q && waddr_q == abs_track_pkg::OFS_ORIGIN |=> origin_q == clamp_origin($past(hwdata));
   endproperty
   a_origin_now: assert property (p_origin_now) else $error("origin write not taken at once");

   property p_pos17;
      smp_valid && etype_q != abs_track_pkg::ENC_MULTI_OPT && $stable(etype_q) |=> in_turn_q[31:17] == 15'h0000;
   endproperty
   a_pos17: assert property (p_pos17) else $error("17-bit position exceeds range");

   property p_pos23;
      enc.valid && etype_q == abs_track_pkg::ENC_MULTI_OPT ##1 $stable(etype_q) |=> in_turn_q == {9'h000, $past(enc.pos, 2)};
   endproperty
   a_pos23: assert property (p_pos23) else $error("23-bit position not passed through");

   property p_single_no_turns;
      enc.valid && etype_q == abs_track_pkg::ENC_SINGLE_MAG && turn_base_q == 16'h0000 ##1 state_q == abs_track_pkg::CMD_IDLE
      |=> revs_q == 32'h0000_0000;
   endproperty
   a_single_no_turns: assert property (p_single_no_turns) else $error("single-turn shows turns");

   property p_track;
      smp_valid && state_q == abs_track_pkg::CMD_IDLE |=> cur_q == $past(org_base_q) + $past(abs_delta[31:0]);
   endproperty
   a_track: assert property (p_track) else $error("position not formed from encoder");

endmodule : absolute_position_tracker
`default_nettype wire

// ---- test/enc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module enc_model (
   // Clock
   input  wire logic                      mclk,
   // Report requests from the bench
   input  wire logic                      send,
   input  wire logic                      load,
   input  wire logic                      fault_in,
   input  wire logic [15:0]               turns_in,
   input  wire logic [22:0]               pos_in,
   // Drive side of the link
   input  wire logic                      clear_turns,
   output var abs_track_pkg::enc_sample_t enc
);
   logic [15:0] turns_q = 16'h0000;

   initial enc = '0;

   // Turn count lives on battery: no reset input, so a drive reset leaves it alone
   always @(posedge mclk) begin
      if (clear_turns) begin
         turns_q <= 16'h0000;
      end else if (load) begin
         turns_q <= turns_in;
      end
   end

   // One report per request; between reports the lines toggle so stale data never looks steady
   always @(posedge mclk) begin
      if (send) begin
         enc <= '{valid: 1'b1, fault: fault_in, turns: load ? turns_in : turns_q, pos: pos_in};
      end else begin
         enc <= '{valid: 1'b0, fault: 1'b0, turns: ~enc.turns, pos: ~enc.pos};
      end
   end
endmodule : enc_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                       mclk;
   logic                       rst_n;
   logic                       hsel;
   logic [31:0]                haddr;
   logic [1:0]                 htrans;
   logic                       hwrite;
   logic [2:0]                 hsize;
   logic [31:0]                hwdata;
   logic                       hreadyout;
   logic [31:0]                hrdata;
   logic                       hresp;
   abs_track_pkg::enc_sample_t enc;
   logic                       enc_clear_turns;
   logic [31:0]                cur_position;
   logic                       send;
   logic                       load;
   logic                       fault_in;
   logic [15:0]                turns_in;
   logic [22:0]                pos_in;
   logic [31:0]                exp_pos;
   logic [31:0]                seen;
   logic [31:0]                org;
   int                         err_total;
   int                         checks;

   absolute_position_tracker u_dut (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hreadyout),
      .hreadyout       (hreadyout),
      .hrdata          (hrdata),
      .hresp           (hresp),
      .enc             (enc),
      .enc_clear_turns (enc_clear_turns),
      .cur_position    (cur_position)
   );

   enc_model u_enc (
      .mclk        (mclk),
      .send        (send),
      .load        (load),
      .fault_in    (fault_in),
      .turns_in    (turns_in),
      .pos_in      (pos_in),
      .clear_turns (enc_clear_turns),
      .enc         (enc)
   );

   // 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Verdict and end of run
   task automatic results();
      if (err_total == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   // One compare for every 32-bit result
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Samples hready at rising edges; a bounded wait so a stuck slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            err_total++;
            $display("wrong value at %0t: bus never ready", $time);
            results();
         end
         @(posedge mclk);
      end
   endtask : wait_ready

   // Single AHB-Lite word transfer: address phase, then data phase
   task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdata);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      hwrite <= is_wr;
      htrans <= abs_track_pkg::HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rdata = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk(r, e, what);
   endtask : rd

   // One encoder report carrying its own turn count
   task automatic report(input logic [15:0] t, input logic [22:0] p, input logic f);
      send     <= 1'b1;
      load     <= 1'b1;
      turns_in <= t;
      pos_in   <= p;
      fault_in <= f;
      @(posedge mclk);
      send <= 1'b0;
      load <= 1'b0;
      repeat (5) @(posedge mclk);
   endtask : report

   // Counts clear requests to the encoder over a short window
   task automatic pulses(input logic [31:0] want);
      logic [31:0] n;
      n = 32'h0;
      repeat (6) begin
         @(posedge mclk);
         n = n + {31'h0, enc_clear_turns};
      end
      chk(n, want, "clear pulses");
   endtask : pulses

   initial begin
      rst_n     = 1'b0;
      hsel      = 1'b0;
      haddr     = 32'h0;
      htrans    = 2'h0;
      hwrite    = 1'b0;
      hsize     = 3'h2;
      hwdata    = 32'h0;
      send      = 1'b0;
      load      = 1'b0;
      fault_in  = 1'b0;
      turns_in  = 16'h0;
      pos_in    = 23'h0;
      err_total = 0;
      checks    = 0;
      repeat (5) @(posedge mclk);
      chk({31'h0, hreadyout}, 32'h0, "ready in reset");
      rst_n <= 1'b1;
      @(posedge mclk);
      chk(cur_position, 32'h0, "position after reset");
      chk({31'h0, hresp}, 32'h0, "bus response");
      rd(abs_track_pkg::OFS_RESET_CMD, 32'h0, "command default");
      rd(abs_track_pkg::OFS_ORIGIN, 32'h0, "origin default");
      rd(abs_track_pkg::OFS_ENC_TYPE, 32'h1, "kind default");
      rd(abs_track_pkg::OFS_STATUS, 32'h0, "status default");
      rd(8'h1c, 32'h0, "unmapped read");
      // Every encoder kind with a position whose upper bits a 17-bit kind must drop
      for (int k = 0; k < 3; k++) begin
         wr(abs_track_pkg::OFS_ENC_TYPE, 32'(k));
         report(16'h0123, 23'h7ffffe, 1'b0);
         exp_pos = (k == 2) ? 32'h007f_fffe : 32'h0001_fffe;
         rd(abs_track_pkg::OFS_IN_TURN, exp_pos, "in-turn");
         rd(abs_track_pkg::OFS_REVS, (k == 0) ? 32'h0 : 32'h123, "revolutions");
         exp_pos = exp_pos + ((k == 0) ? 32'h0 : (32'h123 << ((k == 2) ? 23 : 17)));
         rd(abs_track_pkg::OFS_CUR_POS, exp_pos, "position reg");
         chk(cur_position, exp_pos, "position port");
      end
      // Undefined kind code is refused
      wr(abs_track_pkg::OFS_ENC_TYPE, 32'h3);
      rd(abs_track_pkg::OFS_ENC_TYPE, 32'h2, "kind refused");
      wr(abs_track_pkg::OFS_ENC_TYPE, 32'h1);
      // Origin offset limits
      wr(abs_track_pkg::OFS_ORIGIN, 32'h8000_0000);
      rd(abs_track_pkg::OFS_ORIGIN, 32'h8000_0001, "origin low limit");
      wr(abs_track_pkg::OFS_ORIGIN, 32'h7fff_ffff);
      rd(abs_track_pkg::OFS_ORIGIN, 32'h7fff_fffe, "origin high limit");
      // Fault, then command values that must do nothing
      report(16'h0007, 23'h00abcd, 1'b1);
      seen = cur_position;
      rd(abs_track_pkg::OFS_STATUS, 32'h1, "fault flag");
      wr(abs_track_pkg::OFS_RESET_CMD, 32'h0);
      pulses(32'h0);
      wr(abs_track_pkg::OFS_RESET_CMD, 32'h2);
      pulses(32'h0);
      chk(cur_position, seen, "no-op kept position");
      rd(abs_track_pkg::OFS_STATUS, 32'h1, "fault kept");
      // Calibration: write origin, then issue the reset
      org = 32'hffff_cfc7;
      wr(abs_track_pkg::OFS_ORIGIN, org);
      rd(abs_track_pkg::OFS_ORIGIN, org, "origin at once");
      wr(abs_track_pkg::OFS_RESET_CMD, 32'h1);
      pulses(32'h1);
      chk(cur_position, org, "position loaded");
      rd(abs_track_pkg::OFS_CUR_POS, org, "position reg loaded");
      rd(abs_track_pkg::OFS_REVS, 32'h0, "revolutions cleared");
      rd(abs_track_pkg::OFS_STATUS, 32'h0, "fault cleared");
      rd(abs_track_pkg::OFS_RESET_CMD, 32'h0, "command back to no-op");
      // Origin return: the position now moves from the loaded origin
      report(16'h0008, 23'h000000, 1'b0);
      exp_pos = org + (32'h8 << 17) - ((32'h7 << 17) + 32'h0000_abcd);
      rd(abs_track_pkg::OFS_CUR_POS, exp_pos, "position after return");
      rd(abs_track_pkg::OFS_REVS, 32'h1, "turns since reset");
      // A second write acts once more
      wr(abs_track_pkg::OFS_RESET_CMD, 32'h1);
      pulses(32'h1);
      // A read right behind the write sees the one applying cycle
      wr(abs_track_pkg::OFS_RESET_CMD, 32'h1);
      rd(abs_track_pkg::OFS_STATUS, 32'h2, "busy while applying");
      // Drive reset mid-run: the position comes back from the encoder alone
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      chk({31'h0, hreadyout}, 32'h0, "ready in second reset");
      rst_n <= 1'b1;
      @(posedge mclk);
      report(16'h0009, 23'h000100, 1'b0);
      rd(abs_track_pkg::OFS_CUR_POS, (32'h9 << 17) + 32'h100, "position after power-up");
      rd(abs_track_pkg::OFS_REVS, 32'h9, "turns after power-up");
      results();
   end
endmodule : tb
`default_nettype wire
